// ### design/cabr_params.svh
`ifndef CABR_PARAMS_SVH
`define CABR_PARAMS_SVH

// Register offsets in the controller's operational space
`define CABR_OFS_INT_ENABLE 8'h10
`define CABR_OFS_INT_DISABLE 8'h14
`define CABR_OFS_COMM_AREA_BASE 8'h18

// Field positions
`define CABR_SO_BIT 0
`define CABR_BASE_MSB 31
`define CABR_BASE_LSB 8
`define CABR_TABLE_IDX_LSB 2

// Reset values
`define CABR_BASE_RESET 24'h000000
`define CABR_SO_EN_RESET 1'b0
`define CABR_READ_IDLE 32'h00000000

`endif

// ### design/cabr_pkg.sv
package cabr_pkg;
  typedef logic [31:0] cabr_word_t;
  typedef logic [7:0] cabr_addr_t;
  typedef logic [23:0] cabr_base_t;
  typedef logic [4:0] cabr_frame_t;
endpackage

// ### design/cabr_ctl_if.sv
`timescale 1ns/1ps
interface cabr_ctl_if;
  logic en_wr;
  logic dis_wr;
  logic so_en;
  modport regs (output en_wr, output dis_wr, input so_en);
  modport gate (input en_wr, input dis_wr, output so_en);
endinterface // cabr_ctl_if

// ### design/cabr_so_gate.sv
`timescale 1ns/1ps
`include "cabr_params.svh"
module cabr_so_gate (
  input wire logic clock,
  input wire logic srst,
  cabr_ctl_if.gate ctl,
  input wire logic so_event,
  output logic so_irq
);
  logic so_en_q;
  logic so_en_d;

  // Enable set by the enable register, cleared by reset or by a 1 to the disable register
  // Disable write stops
  assign so_en_d = ctl.dis_wr ? 1'b0 : (ctl.en_wr ? 1'b1 : so_en_q);

  always_ff @(posedge clock) begin
    if (srst) begin
      so_en_q <= `CABR_SO_EN_RESET;
    end else begin
      so_en_q <= so_en_d;
    end
  end

  assign ctl.so_en = so_en_q;

  // Gated request; combinational so a disabled overrun never reaches the line
  // Interrupt gating applied
  assign so_irq = so_event & so_en_q;

  chk_so_disable_holds: assert property (@(posedge clock) disable iff (srst)
    ctl.dis_wr |=> (!so_irq && !so_en_q)) else $error("overrun interrupt after disable write");
endmodule // cabr_so_gate

// ### design/cabr_regs.sv
`timescale 1ns/1ps
`include "cabr_params.svh"
module cabr_regs (
  input wire logic clock,
  input wire logic srst,
  input wire cabr_pkg::cabr_addr_t reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [3:0] reg_be,
  input wire cabr_pkg::cabr_word_t reg_wdata,
  output cabr_pkg::cabr_word_t reg_rdata,
  output logic reg_rvalid,
  input wire logic so_event,
  output logic so_irq,
  input wire cabr_pkg::cabr_frame_t frame_index,
  output cabr_pkg::cabr_word_t comm_area_base,
  output cabr_pkg::cabr_word_t intr_table_addr
);
  cabr_ctl_if ctl ();

  cabr_pkg::cabr_base_t base_q;
  cabr_pkg::cabr_base_t base_d;
  cabr_pkg::cabr_word_t rdata_q;
  cabr_pkg::cabr_word_t rdata_d;
  cabr_pkg::cabr_word_t table_q;
  logic rvalid_q;

  // Full register image: reserved low byte is never stored, so it reads zero
  function automatic cabr_pkg::cabr_word_t base_word(input cabr_pkg::cabr_base_t b);
    base_word = {b, 8'h00};
  endfunction

  // Address decode
  wire sel_base = (reg_addr == `CABR_OFS_COMM_AREA_BASE);
  wire sel_dis = (reg_addr == `CABR_OFS_INT_DISABLE);
  wire sel_en = (reg_addr == `CABR_OFS_INT_ENABLE);
  wire wr_base = reg_wr & sel_base;

  // Only a 1 in the overrun bit counts
  assign ctl.dis_wr = reg_wr & sel_dis & reg_be[0] & reg_wdata[`CABR_SO_BIT];
  assign ctl.en_wr = reg_wr & sel_en & reg_be[0] & reg_wdata[`CABR_SO_BIT];

  // Lane 0 carries only reserved bits and is dropped
  assign base_d = {
    reg_be[3] ? reg_wdata[31:24] : base_q[23:16],
    reg_be[2] ? reg_wdata[23:16] : base_q[15:8],
    reg_be[1] ? reg_wdata[15:8] : base_q[7:0]
  };

  // Read mux; unmapped offsets read zero so a probe never faults
  // Base low byte forced to zero; the enable offsets return the overrun enable in bit 0
  wire cabr_pkg::cabr_word_t so_word = {31'h00000000, ctl.so_en};
  assign rdata_d = sel_base ? base_word(base_q) :
                   (sel_dis | sel_en) ? so_word : `CABR_READ_IDLE;

  always_ff @(posedge clock) begin
    if (srst) begin
      base_q <= `CABR_BASE_RESET;
    end else if (wr_base) begin
      base_q <= base_d;
    end
  end

  // Read data registered, answered one cycle after the strobe
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= `CABR_READ_IDLE;
      rvalid_q <= 1'b0;
    end else begin
      rvalid_q <= reg_rd;
      if (reg_rd) begin
        rdata_q <= rdata_d;
      end
    end
  end

  // Interrupt-table entry address for the current frame
  // Entries are words at the area's start; registered to keep the DMA path short
  always_ff @(posedge clock) begin
    if (srst) begin
      table_q <= `CABR_READ_IDLE;
    end else begin
      table_q <= base_word(base_q) | {25'h0000000, frame_index, 2'b00};
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign comm_area_base = base_word(base_q);
  assign intr_table_addr = table_q;

  cabr_so_gate u_so_gate (
    .clock(clock),
    .srst(srst),
    .ctl(ctl.gate),
    .so_event(so_event),
    .so_irq(so_irq)
  );

  chk_base_readback: assert property (@(posedge clock) disable iff (srst)
    (reg_rd && sel_base && !reg_wr) |=> (reg_rvalid && reg_rdata == comm_area_base))
    else $error("base read does not return stored base");

  chk_base_write_lands: assert property (@(posedge clock) disable iff (srst)
    (wr_base && reg_be == 4'hf) |=> (comm_area_base[31:8] == $past(reg_wdata[31:8])))
    else $error("base field not updated by write");

  chk_low_byte_zero: assert property (@(posedge clock) disable iff (srst)
    reg_rvalid && $past(sel_base) |-> reg_rdata[7:0] == 8'h00)
    else $error("base low byte not zero on read");

  chk_lane0_ignored: assert property (@(posedge clock) disable iff (srst)
    (wr_base && reg_be == 4'h1) |=> $stable(comm_area_base))
    else $error("reserved lane write changed base");

  chk_zero_no_effect: assert property (@(posedge clock) disable iff (srst)
    (reg_wr && sel_dis && !reg_wdata[0] && !ctl.en_wr) |=> $stable(ctl.so_en))
    else $error("zero write altered overrun enable");

  chk_table_addr: assert property (@(posedge clock) disable iff (srst)
    ##1 intr_table_addr == ($past(comm_area_base) | {25'h0000000, $past(frame_index), 2'b00}))
    else $error("table address does not track base");

  // Read handshake: the answer follows the strobe one cycle later and lasts as long as it, data holds between reads
  // so a slow bus bridge may pick it up late without losing it

  chk_rvalid_follows_rd: assert property (@(posedge clock) disable iff (srst)
    reg_rd
    |=> reg_rvalid)
    else $error("read strobe not answered");

  chk_rvalid_idle: assert property (@(posedge clock) disable iff (srst)
    !reg_rd
    |=> !reg_rvalid)
    else $error("read answer without read strobe");

  chk_rdata_holds: assert property (@(posedge clock) disable iff (srst)
    !reg_rd
    |=> $stable(reg_rdata))
    else $error("read data changed without read");

  chk_unmapped_read_zero: assert property (@(posedge clock) disable iff (srst)
    (reg_rd && !sel_base && !sel_dis && !sel_en)
    |=> (reg_rdata == 32'h00000000))
    else $error("unmapped offset read not zero");

  chk_unmapped_write_kept: assert property (@(posedge clock) disable iff (srst)
    (reg_wr && !sel_base)
    |=> $stable(comm_area_base))
    else $error("write elsewhere changed base");

  chk_mid_lane_merge: assert property (@(posedge clock) disable iff (srst)
    (wr_base && reg_be == 4'h6)
    |=> (comm_area_base[31:24] == $past(comm_area_base[31:24]) && comm_area_base[23:8] == $past(reg_wdata[23:8])))
    else $error("middle lane write merged wrongly");

  chk_top_lane_merge: assert property (@(posedge clock) disable iff (srst)
    (wr_base && reg_be == 4'h8)
    |=> (comm_area_base[31:24] == $past(reg_wdata[31:24]) && comm_area_base[23:8] == $past(comm_area_base[23:8])))
    else $error("top lane write merged wrongly");

  chk_base_read_value: assert property (@(posedge clock) disable iff (srst)
    (reg_rd && sel_base)
    |=> (reg_rdata[31:8] == $past(comm_area_base[31:8])))
    else $error("base read field differs from stored base");

  // Reset checks run through reset itself, so they carry no disable clause

  chk_base_reset_zero: assert property (@(posedge clock)
    srst
    |=> (comm_area_base == 32'h00000000))
    else $error("base not cleared by reset");

  chk_read_reset: assert property (@(posedge clock)
    srst
    |=> (!reg_rvalid && reg_rdata == 32'h00000000))
    else $error("read side not cleared by reset");

  chk_so_reset_off: assert property (@(posedge clock)
    srst
    |=> !ctl.so_en)
    else $error("overrun enable set after reset");

  chk_table_reset: assert property (@(posedge clock)
    srst
    |=> (intr_table_addr == 32'h00000000))
    else $error("table address not cleared by reset");

  chk_enable_sets: assert property (@(posedge clock) disable iff (srst)
    (ctl.en_wr && !ctl.dis_wr)
    |=> ctl.so_en)
    else $error("enable write did not set overrun enable");

  chk_so_readback: assert property (@(posedge clock) disable iff (srst)
    (reg_rd && (sel_dis || sel_en))
    |=> (reg_rdata == {31'h00000000, $past(ctl.so_en)}))
    else $error("overrun enable read back wrong");
endmodule // cabr_regs

// ### tb/comm_area_base_register_tb.sv
`timescale 1ns/1ps
module comm_area_base_register_tb;
  logic clock = 1'b0;
  logic srst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic so_event = 1'b0;
  logic [3:0] reg_be = 4'hf;
  cabr_pkg::cabr_addr_t reg_addr = 8'h00;
  cabr_pkg::cabr_word_t reg_wdata = 32'h0;
  cabr_pkg::cabr_frame_t frame_index = 5'h00;
  cabr_pkg::cabr_word_t reg_rdata, comm_area_base, intr_table_addr, rd_q;
  logic reg_rvalid, so_irq;
  int miscompares = 0;
  int checked = 0;
  // 200 MHz clock
  always #2.5 clock = ~clock;
  cabr_regs dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .so_event(so_event), .so_irq(so_irq), .frame_index(frame_index), .comm_area_base(comm_area_base),
    .intr_table_addr(intr_table_addr));
  // Case equality so an unknown never passes
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One-cycle write strobe, launched off the falling edge
  task wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge clock);
    reg_addr = a;
    reg_be = be;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clock);
    reg_wr = 1'b0;
  endtask
  // Answer is due exactly one cycle after the strobe
  task rd(input logic [7:0] a);
    @(negedge clock);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clock);
    reg_rd = 1'b0;
    chk("rvalid", 32'h1, {31'h0, reg_rvalid});
    rd_q = reg_rdata;
    @(negedge clock);
    chk("rvalid drop", 32'h0, {31'h0, reg_rvalid});
    chk("rdata hold", rd_q, reg_rdata);
  endtask
  task reset_values;
    so_event = 1'b1;
    chk("base after reset", 32'h0, comm_area_base);
    rd(8'h18);
    chk("base read after reset", 32'h0, rd_q);
    chk("irq after reset", 32'h0, {31'h0, so_irq});
  endtask
  // Alignment probe as driver software does it
  task align_probe;
    wr(8'h18, 4'hf, 32'hffffffff);
    rd(8'h18);
    chk("probe read", 32'hffffff00, rd_q);
    chk("base pointer", 32'hffffff00, comm_area_base);
  endtask
  task lane_write;
    wr(8'h18, 4'h1, 32'h000000aa);
    chk("lane0 only", 32'hffffff00, comm_area_base);
    frame_index = 5'h1f;
    wr(8'h18, 4'h6, 32'h12345678);
    chk("mid lanes", 32'hff345600, comm_area_base);
    // Table address trails the base by one cycle
    @(negedge clock);
    chk("table entry", 32'hff34567c, intr_table_addr);
  endtask
  // Unmapped offset must not alias onto the base register
  task unmapped;
    wr(8'h1c, 4'hf, 32'h0);
    chk("unmapped write", 32'hff345600, comm_area_base);
    rd(8'h1c);
    chk("unmapped read", 32'h0, rd_q);
  endtask
  task overrun;
    wr(8'h10, 4'hf, 32'h1);
    chk("irq enabled", 32'h1, {31'h0, so_irq});
    wr(8'h14, 4'hf, 32'h0);
    chk("zero ignored", 32'h1, {31'h0, so_irq});
    wr(8'h14, 4'hf, 32'h1);
    chk("irq disabled", 32'h0, {31'h0, so_irq});
    rd(8'h14);
    chk("enable readback", 32'h0, rd_q & 32'h1);
    wr(8'h10, 4'hf, 32'h1);
    rd(8'h10);
    chk("enable set readback", 32'h1, rd_q);
    so_event = 1'b0;
    @(negedge clock);
    chk("irq without event", 32'h0, {31'h0, so_irq});
  endtask
  task test_done;
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock);
    srst = 1'b0;
    reset_values();
    align_probe();
    lane_write();
    unmapped();
    overrun();
    test_done();
  end
  // Whole run needs well under 200 cycles
  initial begin
    repeat (2000) @(posedge clock);
    miscompares++;
    test_done();
  end
endmodule // comm_area_base_register_tb
